// [rtl/seq_params.svh]
// Constants for the protocol microsequencer: memory map, encodings, reset values
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

`define SEQ_CLK_PERIOD_NS 25
`define SEQ_INSTR_CYCLE_NS 50
`define SEQ_INSTR_CLKS (`SEQ_INSTR_CYCLE_NS / `SEQ_CLK_PERIOD_NS)
`define SEQ_INSTR_W 14
`define SEQ_DATA_W 8
`define SEQ_MODE_MSB 13
`define SEQ_MODE_LSB 12
`define SEQ_FUNC_MSB 11
`define SEQ_FUNC_LSB 8
`define SEQ_FIELD_MSB 7

`define SEQ_UP_REGION_IMEM 2'h0
`define SEQ_UP_REGION_RF 2'h1
`define SEQ_UP_CTRL 10'h200
`define SEQ_UP_PC 10'h201
`define SEQ_UP_ACC 10'h202
`define SEQ_UP_FWVEC_A 10'h203
`define SEQ_UP_FWVEC_B 10'h204
`define SEQ_UP_STATUS 10'h205

`define SEQ_CTRL_RUN_BIT 0
`define SEQ_PC_RESET 8'h00
`define SEQ_FWVEC_A_RESET 8'h40
`define SEQ_FWVEC_B_RESET 8'h60
`define SEQ_HW1_ENTRY 8'h78
`define SEQ_HW0_BASE_BIT 1'h1
`define SEQ_HW0_SLOT_PAD 3'h0
`define SEQ_HW_STATUS_REG 5'h1f

`endif

// [rtl/seq_pkg.sv]
// Types shared by the protocol microsequencer
package seq_pkg;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_FETCH  = 3'b001,
        S_EXEC   = 3'b010,
        S_FLUSH1 = 3'b011,
        S_FLUSH2 = 3'b100
    } state_t;

    typedef enum logic [1:0] {
        M_DIR = 2'b00,
        M_IND = 2'b01,
        M_ABS = 2'b10,
        M_IMM = 2'b11
    } mode_t;

    typedef enum logic [3:0] {
        F_LD   = 4'h0,
        F_ST   = 4'h1,
        F_ADD  = 4'h2,
        F_SUB  = 4'h3,
        F_AND  = 4'h4,
        F_OR   = 4'h5,
        F_XOR  = 4'h6,
        F_CMP  = 4'h7,
        F_JMP  = 4'h8,
        F_JZ   = 4'h9,
        F_JNZ  = 4'ha,
        F_JC   = 4'hb,
        F_CALL = 4'hc,
        F_RET  = 4'hd,
        F_RETI = 4'he,
        F_HALT = 4'hf
    } func_t;

endpackage

// [rtl/scsi_protocol_microsequencer.sv]
// Programmable protocol microsequencer with microprocessor load port and chip access bus
// Function
// - A non-branch instruction completes every 50 ns, up to 20 MIPS.
// - Sixteen operations, each one single 14-bit instruction word.
// - Datapath, ALU and operands are eight bits wide.
// - Instruction memory holds 256 words addressed by the program counter.
// - Thirty-two byte registers plus special registers and an integer ALU.
// - Hardware return stack five entries deep.
// - Operands use direct, indirect, absolute or immediate addressing.
// - Instruction and data memories are separate and accessed at once.
// - Fetch and execute take one clock each, writeback at the end of execute; two clocks, taken branches four.
// - Programs reach internal registers, SCSI FIFO, DRAM buffer, all chip registers.
// - Two independent firmware interrupt sources raised by the microprocessor.
// - Firmware interrupts are serviced without halting the running program.
// - Firmware vectors stay writable while running; new value used next time.
// - Two hardware interrupts from the SCSI module, one with vector and status.
// - A setting passes hardware interrupts through or lets the sequencer intercept.
// - Intercepted hardware interrupt 0 dispatches on the vector input and latches the status; interrupt 1 enters at a fixed address.
// - Microprocessor bus loads and inspects program, registers and control words; the return stack is not reachable.
`include "seq_params.svh"

module scsi_protocol_microsequencer
    import seq_pkg::*;
#(
    parameter int IMEM_DEPTH = 256,
    parameter int RF_DEPTH = 32,
    parameter int STACK_DEPTH = 5
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Microprocessor port
    input wire logic up_sel_i,
    input wire logic up_we_i,
    input wire logic [9:0] up_addr_i,
    input wire logic [15:0] up_wdata_i,
    output logic [15:0] up_rdata_o,
    output logic [1:0] up_hw_irq_o,
    // Firmware interrupts
    input wire logic firmware_interrupt_a_i,
    input wire logic firmware_interrupt_b_i,
    // SCSI module hardware interrupts
    input wire logic hw_intercept_i,
    input wire logic hw_irq0_i,
    input wire logic hw_irq1_i,
    input wire logic [3:0] hw_vec_i,
    input wire logic [7:0] hw_status_i,
    // Chip access bus
    output logic [7:0] cbus_addr_o,
    output logic [7:0] cbus_wdata_o,
    output logic cbus_rd_o,
    output logic cbus_wr_o,
    input wire logic [7:0] cbus_rdata_i,
    // Status
    output logic running_o,
    output logic stack_fault_o
);
    localparam int PCW = $clog2(IMEM_DEPTH);
    localparam int RFW = $clog2(RF_DEPTH);
    localparam int SPW = $clog2(STACK_DEPTH + 1);

    logic [`SEQ_INSTR_W-1:0] imem [IMEM_DEPTH];
    logic [`SEQ_DATA_W-1:0] rf [RF_DEPTH];
    logic [PCW-1:0] stk [STACK_DEPTH];

    state_t state;
    logic run;
    logic [PCW-1:0] pc;
    logic [SPW-1:0] sp;
    logic [`SEQ_INSTR_W-1:0] ir;
    logic [7:0] opreg;
    logic [7:0] acc;
    logic zf;
    logic cf;
    logic in_service;
    logic [7:0] fwvec_a;
    logic [7:0] fwvec_b;
    logic [3:0] pend;
    logic [3:0] src;
    logic [3:0] grant;
    logic [PCW-1:0] irq_target;

    logic [`SEQ_INSTR_W-1:0] instr;
    mode_t f_mode;
    func_t f_fn;
    logic [7:0] f_fld;
    mode_t ir_mode;
    func_t ir_fn;
    logic [7:0] ir_fld;
    logic [7:0] opnd;
    logic [8:0] alu_res;
    logic acc_wr;
    logic flag_wr;
    logic taken;
    logic push;
    logic pop;
    logic take_irq;
    logic up_wr;

    // Separate instruction store lets fetch run while data is accessed
    assign instr = imem[pc[PCW-1:0]];
    assign f_mode = mode_t'(instr[`SEQ_MODE_MSB:`SEQ_MODE_LSB]);
    assign f_fn = func_t'(instr[`SEQ_FUNC_MSB:`SEQ_FUNC_LSB]);
    assign f_fld = instr[`SEQ_FIELD_MSB:0];
    assign ir_mode = mode_t'(ir[`SEQ_MODE_MSB:`SEQ_MODE_LSB]);
    assign ir_fn = func_t'(ir[`SEQ_FUNC_MSB:`SEQ_FUNC_LSB]);
    assign ir_fld = ir[`SEQ_FIELD_MSB:0];
    assign up_wr = up_sel_i && up_we_i;
    assign running_o = run;

    // Interrupt sources, hardware ones only when intercepted
    assign src = {firmware_interrupt_b_i, firmware_interrupt_a_i,
                  hw_irq1_i && hw_intercept_i, hw_irq0_i && hw_intercept_i};
    assign take_irq = (state == S_FETCH) && run && !in_service && (|pend);

    // Fixed priority: hardware before firmware
    always_comb begin
        grant = 4'h0;
        irq_target = `SEQ_PC_RESET;
        if (take_irq) begin
            if (pend[0]) begin
                grant = 4'h1;
                irq_target = {`SEQ_HW0_BASE_BIT, hw_vec_i, `SEQ_HW0_SLOT_PAD};
            end else if (pend[1]) begin
                grant = 4'h2;
                irq_target = `SEQ_HW1_ENTRY;
            end else if (pend[2]) begin
                grant = 4'h4;
                irq_target = fwvec_a;
            end else begin
                grant = 4'h8;
                irq_target = fwvec_b;
            end
        end
    end

    // Sticky pending flags; a new event in the grant cycle is kept
    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_pend
        always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
                pend[gi] <= 1'b0;
            end else if (src[gi]) begin
                pend[gi] <= 1'b1;
            end else if (grant[gi]) begin
                pend[gi] <= 1'b0;
            end
        end
    end

    // Pass-through copy of the hardware interrupts to the microprocessor
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            up_hw_irq_o <= 2'h0;
        end else begin
            up_hw_irq_o <= {hw_irq1_i, hw_irq0_i} & {2{!hw_intercept_i}};
        end
    end

    // Operand select and ALU
    always_comb begin
        unique case (ir_mode)
            M_DIR: opnd = opreg;
            M_IND: opnd = cbus_rdata_i;
            M_ABS: opnd = cbus_rdata_i;
            M_IMM: opnd = ir_fld;
        endcase
        alu_res = {1'b0, acc};
        acc_wr = 1'b0;
        flag_wr = 1'b0;
        taken = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        unique case (ir_fn)
            F_LD: begin
                alu_res = {1'b0, opnd};
                acc_wr = 1'b1;
            end
            F_ST: alu_res = {1'b0, acc};
            F_ADD: begin
                alu_res = {1'b0, acc} + {1'b0, opnd};
                acc_wr = 1'b1;
                flag_wr = 1'b1;
            end
            F_SUB, F_CMP: begin
                alu_res = {1'b0, acc} - {1'b0, opnd};
                acc_wr = (ir_fn == F_SUB);
                flag_wr = 1'b1;
            end
            F_AND: begin
                alu_res = {1'b0, acc & opnd};
                acc_wr = 1'b1;
                flag_wr = 1'b1;
            end
            F_OR: begin
                alu_res = {1'b0, acc | opnd};
                acc_wr = 1'b1;
                flag_wr = 1'b1;
            end
            F_XOR: begin
                alu_res = {1'b0, acc ^ opnd};
                acc_wr = 1'b1;
                flag_wr = 1'b1;
            end
            F_JMP: taken = 1'b1;
            F_JZ: taken = zf;
            F_JNZ: taken = !zf;
            F_JC: taken = cf;
            F_CALL: begin
                taken = 1'b1;
                push = 1'b1;
            end
            F_RET, F_RETI: begin
                taken = 1'b1;
                pop = 1'b1;
            end
            F_HALT: alu_res = {1'b0, acc};
        endcase
    end

    // Accumulator and flags
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            acc <= 8'h00;
            zf <= 1'b0;
            cf <= 1'b0;
        end else if (state == S_EXEC) begin
            if (acc_wr) begin
                acc <= alu_res[7:0];
            end
            if (flag_wr) begin
                zf <= (alu_res[7:0] == 8'h00);
                cf <= alu_res[8];
            end
        end else if (up_wr && up_addr_i == `SEQ_UP_ACC && state == S_IDLE) begin
            acc <= up_wdata_i[7:0];
        end
    end

    // Run control: started only by the microprocessor, stopped by it or by a halt
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            run <= 1'b0;
        end else if (state == S_EXEC && ir_fn == F_HALT) begin
            run <= 1'b0;
        end else if (up_wr && up_addr_i == `SEQ_UP_CTRL) begin
            run <= up_wdata_i[`SEQ_CTRL_RUN_BIT];
        end
    end

    // Sequencing, program counter and return stack
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            pc <= `SEQ_PC_RESET;
            sp <= '0;
            ir <= '0;
            in_service <= 1'b0;
            stack_fault_o <= 1'b0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (run) begin
                        state <= S_FETCH;
                    end else if (up_wr && up_addr_i == `SEQ_UP_PC) begin
                        pc <= up_wdata_i[PCW-1:0];
                    end
                end
                S_FETCH: begin
                    if (!run) begin
                        state <= S_IDLE;
                    end else if (take_irq) begin
                        // Entry acts as a call so the interrupted program resumes intact
                        if (sp == SPW'(STACK_DEPTH)) begin
                            stack_fault_o <= 1'b1;
                        end else begin
                            stk[sp] <= pc;
                            sp <= sp + SPW'(1);
                        end
                        pc <= irq_target;
                        in_service <= 1'b1;
                        state <= S_FLUSH1;
                    end else begin
                        ir <= instr;
                        pc <= pc + PCW'(1);
                        state <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    state <= taken ? S_FLUSH1 : S_FETCH;
                    if (push) begin
                        if (sp == SPW'(STACK_DEPTH)) begin
                            stack_fault_o <= 1'b1;
                        end else begin
                            stk[sp] <= pc;
                            sp <= sp + SPW'(1);
                        end
                        pc <= opnd[PCW-1:0];
                    end else if (pop) begin
                        if (sp == '0) begin
                            stack_fault_o <= 1'b1;
                        end else begin
                            pc <= stk[sp - SPW'(1)];
                            sp <= sp - SPW'(1);
                        end
                        if (ir_fn == F_RETI) begin
                            in_service <= 1'b0;
                        end
                    end else if (taken) begin
                        pc <= opnd[PCW-1:0];
                    end
                end
                S_FLUSH1: state <= S_FLUSH2;
                S_FLUSH2: state <= S_FETCH;
                default: state <= S_IDLE;
            endcase
        end
    end

    // Chip access set up during fetch so data is present in the execute clock
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cbus_addr_o <= 8'h00;
            cbus_wdata_o <= 8'h00;
            cbus_rd_o <= 1'b0;
            cbus_wr_o <= 1'b0;
            opreg <= 8'h00;
        end else if (state == S_FETCH && run && !take_irq) begin
            cbus_addr_o <= (f_mode == M_IND) ? rf[f_fld[RFW-1:0]] : f_fld;
            cbus_wdata_o <= acc;
            cbus_rd_o <= (f_mode == M_IND || f_mode == M_ABS) && f_fn != F_ST;
            cbus_wr_o <= (f_mode == M_IND || f_mode == M_ABS) && f_fn == F_ST;
            opreg <= rf[f_fld[RFW-1:0]];
        end else begin
            cbus_rd_o <= 1'b0;
            cbus_wr_o <= 1'b0;
        end
    end

    // Register file: sequencer store wins over a same-cycle microprocessor write
    always_ff @(posedge ref_clk_i) begin
        if (state == S_EXEC && ir_fn == F_ST && ir_mode == M_DIR) begin
            rf[ir_fld[RFW-1:0]] <= acc;
        end else if (grant[0]) begin
            rf[`SEQ_HW_STATUS_REG] <= hw_status_i;
        end else if (up_wr && up_addr_i[9:8] == `SEQ_UP_REGION_RF) begin
            rf[up_addr_i[RFW-1:0]] <= up_wdata_i[7:0];
        end
    end

    // Program load; write only while halted to avoid tearing a fetch
    always_ff @(posedge ref_clk_i) begin
        if (up_wr && up_addr_i[9:8] == `SEQ_UP_REGION_IMEM && state == S_IDLE) begin
            imem[up_addr_i[PCW-1:0]] <= up_wdata_i[`SEQ_INSTR_W-1:0];
        end
    end

    // Firmware vectors stay writable at any time
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fwvec_a <= `SEQ_FWVEC_A_RESET;
            fwvec_b <= `SEQ_FWVEC_B_RESET;
        end else if (up_wr && up_addr_i == `SEQ_UP_FWVEC_A) begin
            fwvec_a <= up_wdata_i[7:0];
        end else if (up_wr && up_addr_i == `SEQ_UP_FWVEC_B) begin
            fwvec_b <= up_wdata_i[7:0];
        end
    end

    // Microprocessor read-back, one clock after the select
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            up_rdata_o <= 16'h0000;
        end else if (up_sel_i && !up_we_i) begin
            if (up_addr_i[9:8] == `SEQ_UP_REGION_IMEM) begin
                up_rdata_o <= {2'h0, imem[up_addr_i[PCW-1:0]]};
            end else if (up_addr_i[9:8] == `SEQ_UP_REGION_RF) begin
                up_rdata_o <= {8'h00, rf[up_addr_i[RFW-1:0]]};
            end else if (up_addr_i == `SEQ_UP_CTRL) begin
                up_rdata_o <= {15'h0000, run};
            end else if (up_addr_i == `SEQ_UP_PC) begin
                up_rdata_o <= {8'h00, pc};
            end else if (up_addr_i == `SEQ_UP_ACC) begin
                up_rdata_o <= {8'h00, acc};
            end else if (up_addr_i == `SEQ_UP_FWVEC_A) begin
                up_rdata_o <= {8'h00, fwvec_a};
            end else if (up_addr_i == `SEQ_UP_FWVEC_B) begin
                up_rdata_o <= {8'h00, fwvec_b};
            end else if (up_addr_i == `SEQ_UP_STATUS) begin
                up_rdata_o <= {2'h0, state, stack_fault_o, in_service, pend, zf, cf, SPW'(sp)};
            end else begin
                up_rdata_o <= 16'h0000;
            end
        end
    end

endmodule

// [test/seq_chip_model.sv]
// Chip register space model on the far side of the sequencer's chip access bus
module seq_chip_model (
    // Clock
    input wire logic clk_i,
    // Chip access bus
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic rd_i,
    input wire logic wr_i,
    output logic [7:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256] = '{default: 8'h00};
    logic [7:0] last = 8'h00;
    // Data only in the strobe cycle; inverted otherwise so a late sample shows up
    always_comb rdata_o = rd_i ? mem[addr_i] : ~last;
    always_ff @(posedge clk_i) begin
        if (wr_i) begin
            mem[addr_i] <= wdata_i;
        end
        if (rd_i) begin
            last <= mem[addr_i];
        end
    end
endmodule

// [test/seq_assertions.sv]
// Port-level assertions for the protocol microsequencer
`include "seq_params.svh"
module seq_assertions (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic up_sel_i,
    input wire logic up_we_i,
    input wire logic [9:0] up_addr_i,
    input wire logic [15:0] up_wdata_i,
    input wire logic [15:0] up_rdata_o,
    input wire logic [1:0] up_hw_irq_o,
    input wire logic hw_intercept_i,
    input wire logic hw_irq0_i,
    input wire logic hw_irq1_i,
    input wire logic cbus_rd_o,
    input wire logic cbus_wr_o,
    input wire logic running_o,
    input wire logic stack_fault_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence start_write;
        up_sel_i && up_we_i && up_addr_i == `SEQ_UP_CTRL && up_wdata_i[`SEQ_CTRL_RUN_BIT];
    endsequence
    sequence passing;
        !hw_intercept_i ##1 !hw_intercept_i;
    endsequence
    sequence intercepting;
        hw_intercept_i ##1 hw_intercept_i;
    endsequence
    reset_clears_a: assert property (@(posedge ref_clk_i) disable iff (1'b0)
        rst_i |=> !running_o && !cbus_rd_o && !cbus_wr_o && up_hw_irq_o == 2'h0 && up_rdata_o == 16'h0)
        else $error("outputs not cleared by reset");
    start_runs_a: assert property (start_write |=> running_o)
        else $error("start write did not set run");
    stays_halted_a: assert property (!running_o && !(up_sel_i && up_we_i && up_addr_i == `SEQ_UP_CTRL)
        |=> !running_o) else $error("run rose without a start write");
    halt_quiet_a: assert property (!running_o [*3] |-> !cbus_rd_o && !cbus_wr_o)
        else $error("chip bus active while halted");
    bus_spacing_a: assert property (cbus_rd_o || cbus_wr_o |=> !cbus_rd_o && !cbus_wr_o)
        else $error("chip strobes closer than two clocks");
    bus_exclusive_a: assert property (!(cbus_rd_o && cbus_wr_o))
        else $error("read and write strobes together");
    hw_pass_a: assert property (passing |-> up_hw_irq_o == {$past(hw_irq1_i), $past(hw_irq0_i)})
        else $error("hardware interrupt not passed through");
    hw_block_a: assert property (intercepting |-> up_hw_irq_o == 2'h0)
        else $error("intercepted interrupt reached microprocessor");
    read_hold_a: assert property (!(up_sel_i && !up_we_i) |=> $stable(up_rdata_o))
        else $error("read data changed without a read");
    unmapped_zero_a: assert property (up_sel_i && !up_we_i && up_addr_i[9:8] == 2'h3 |=> up_rdata_o == 16'h0)
        else $error("unmapped read not zero");
    fault_sticky_a: assert property (stack_fault_o |=> stack_fault_o)
        else $error("stack fault flag dropped");
endmodule

// [test/scsi_protocol_microsequencer_test.sv]
// Self-checking bench for the protocol microsequencer
`include "seq_params.svh"
module scsi_protocol_microsequencer_test;
    import seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, up_sel_i = 1'b0, up_we_i = 1'b0;
    logic [9:0] up_addr_i = 10'h000;
    logic [15:0] up_wdata_i = 16'h0000, up_rdata_o;
    logic [1:0] up_hw_irq_o;
    logic fa = 1'b0, fb = 1'b0, hw_intercept_i = 1'b0, hw_irq0_i = 1'b0, hw_irq1_i = 1'b0;
    logic [3:0] hw_vec_i = 4'h0;
    logic [7:0] hw_status_i = 8'h00, cbus_addr_o, cbus_wdata_o, cbus_rdata_i;
    logic cbus_rd_o, cbus_wr_o, running_o, stack_fault_o;
    int errors = 0, checks = 0, cyc = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) cyc <= cyc + 1;
    scsi_protocol_microsequencer dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .up_sel_i(up_sel_i),
        .up_we_i(up_we_i), .up_addr_i(up_addr_i), .up_wdata_i(up_wdata_i), .up_rdata_o(up_rdata_o),
        .up_hw_irq_o(up_hw_irq_o), .firmware_interrupt_a_i(fa), .firmware_interrupt_b_i(fb),
        .hw_intercept_i(hw_intercept_i), .hw_irq0_i(hw_irq0_i), .hw_irq1_i(hw_irq1_i), .hw_vec_i(hw_vec_i),
        .hw_status_i(hw_status_i), .cbus_addr_o(cbus_addr_o), .cbus_wdata_o(cbus_wdata_o),
        .cbus_rd_o(cbus_rd_o), .cbus_wr_o(cbus_wr_o), .cbus_rdata_i(cbus_rdata_i),
        .running_o(running_o), .stack_fault_o(stack_fault_o));
    seq_chip_model chip (.clk_i(ref_clk_i), .addr_i(cbus_addr_o), .wdata_i(cbus_wdata_o),
        .rd_i(cbus_rd_o), .wr_i(cbus_wr_o), .rdata_o(cbus_rdata_i));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic up_wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        up_sel_i <= 1'b1;
        up_we_i <= 1'b1;
        up_addr_i <= a;
        up_wdata_i <= d;
        @(posedge ref_clk_i);
        up_sel_i <= 1'b0;
    endtask
    task automatic up_rd(input logic [9:0] a, output logic [15:0] d);
        @(posedge ref_clk_i);
        up_sel_i <= 1'b1;
        up_we_i <= 1'b0;
        up_addr_i <= a;
        @(posedge ref_clk_i);
        up_sel_i <= 1'b0;
        #1 d = up_rdata_o;
    endtask
    task automatic rd_check(input string what, input logic [9:0] a, input logic [15:0] m, input logic [15:0] e);
        logic [15:0] d;
        up_rd(a, d);
        check(what, d & m, e);
    endtask
    // Waits for a chip strobe at one address; the cycle count feeds timing checks
    task automatic wait_bus(input logic wr, input logic [7:0] a, output int t);
        t = -1;
        for (int i = 0; i < 300 && t < 0; i++) begin
            @(posedge ref_clk_i);
            #1 if ((wr ? cbus_wr_o : cbus_rd_o) === 1'b1 && cbus_addr_o === a) t = cyc;
        end
        check("chip strobe seen", 16'(t >= 0), 16'h1);
    endtask
    // One-clock request: 0 firmware a, 1 firmware b, 2 hardware 0, 3 hardware 1
    task automatic pulse(input int which);
        @(posedge ref_clk_i);
        case (which)
            0: fa <= 1'b1;
            1: fb <= 1'b1;
            2: hw_irq0_i <= 1'b1;
            default: hw_irq1_i <= 1'b1;
        endcase
        @(posedge ref_clk_i);
        {fa, fb, hw_irq0_i, hw_irq1_i} <= 4'h0;
    endtask
    task automatic stop_run();
        up_wr(`SEQ_UP_CTRL, 16'h0000);
        repeat (20) @(posedge ref_clk_i);
        check("stopped", 16'(running_o), 16'h0);
    endtask
    task automatic t_reset();
        rd_check("pc", `SEQ_UP_PC, 16'h00ff, 16'h0000);
        rd_check("vector a", `SEQ_UP_FWVEC_A, 16'h00ff, 16'h0040);
        rd_check("vector b", `SEQ_UP_FWVEC_B, 16'h00ff, 16'h0060);
        rd_check("unmapped", 10'h3ff, 16'hffff, 16'h0000);
        up_wr(10'h0ff, 16'h2abc);
        up_wr(10'h11f, 16'h00c3);
        rd_check("last imem word", 10'h0ff, 16'h3fff, 16'h2abc);
        rd_check("last register", 10'h11f, 16'h00ff, 16'h00c3);
        repeat (5) @(posedge ref_clk_i);
        check("still halted", 16'(running_o), 16'h0);
    endtask
    // Imm load, add, abs store, call, abs add, direct store, halt
    task automatic t_program();
        int t0, t1;
        up_wr(10'h000, 16'h3005);
        up_wr(10'h001, 16'h3203);
        up_wr(10'h002, 16'h2112);
        up_wr(10'h003, 16'h3c10);
        up_wr(10'h004, 16'h2212);
        up_wr(10'h005, 16'h0102);
        up_wr(10'h006, 16'h3f00);
        up_wr(10'h010, 16'h3201);
        up_wr(10'h011, 16'h3d00);
        up_wr(`SEQ_UP_CTRL, 16'h0001);
        wait_bus(1'b1, 8'h12, t0);
        wait_bus(1'b0, 8'h12, t1);
        // One plain and two taken-branch instructions between the strobes, twelve clocks strobe to strobe
        check("strobe spacing", 16'(t1 - t0), 16'd12);
        repeat (20) @(posedge ref_clk_i);
        check("halted", 16'(running_o), 16'h0);
        check("chip write", {8'h00, chip.mem[8'h12]}, 16'h0008);
        rd_check("acc", `SEQ_UP_ACC, 16'h00ff, 16'h0011);
        rd_check("reg 2", 10'h102, 16'h00ff, 16'h0011);
    endtask
    task automatic t_interrupts();
        int t;
        up_wr(10'h020, 16'h3820);
        up_wr(10'h030, 16'h2140);
        up_wr(10'h031, 16'h3e00);
        up_wr(10'h060, 16'h2141);
        up_wr(10'h061, 16'h3e00);
        up_wr(10'h090, 16'h2142);
        up_wr(10'h091, 16'h3e00);
        up_wr(10'h078, 16'h2143);
        up_wr(10'h079, 16'h3e00);
        up_wr(`SEQ_UP_ACC, 16'h005a);
        up_wr(`SEQ_UP_PC, 16'h0020);
        up_wr(`SEQ_UP_CTRL, 16'h0001);
        up_wr(`SEQ_UP_FWVEC_A, 16'h0030);
        pulse(0);
        wait_bus(1'b1, 8'h40, t);
        // The chip model takes the byte at the edge that ends the strobe
        @(posedge ref_clk_i);
        #1 check("handler a", {8'h00, chip.mem[8'h40]}, 16'h005a);
        check("runs on", 16'(running_o), 16'h1);
        pulse(1);
        wait_bus(1'b1, 8'h41, t);
        @(posedge ref_clk_i);
        hw_intercept_i <= 1'b1;
        hw_vec_i <= 4'h2;
        hw_status_i <= 8'ha5;
        pulse(2);
        wait_bus(1'b1, 8'h42, t);
        rd_check("latched status", 10'h11f, 16'h00ff, 16'h00a5);
        pulse(3);
        #1 check("intercepted", 16'(up_hw_irq_o), 16'h0);
        wait_bus(1'b1, 8'h43, t);
        @(posedge ref_clk_i);
        hw_intercept_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        pulse(3);
        #1 check("passed through", 16'(up_hw_irq_o), 16'h2);
        stop_run();
    endtask
    task automatic t_stack_fault();
        check("no fault yet", 16'(stack_fault_o), 16'h0);
        // Indirect store through reg 2 (0x11 from the program test) of acc 0x5a, then an empty pop
        up_wr(10'h050, 16'h1102);
        up_wr(10'h051, 16'h3d00);
        // The failed pop leaves the pc past it, so a halt must stand there
        up_wr(10'h052, 16'h3f00);
        up_wr(`SEQ_UP_PC, 16'h0050);
        up_wr(`SEQ_UP_CTRL, 16'h0001);
        repeat (6) @(posedge ref_clk_i);
        check("empty pop fault", 16'(stack_fault_o), 16'h1);
        check("indirect store", {8'h00, chip.mem[8'h11]}, 16'h005a);
        stop_run();
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_program();
        t_interrupts();
        t_stack_fault();
        wrap_up();
    end
    // Whole run needs a few hundred clocks; this bound of 20000 clocks is far above that
    initial begin
        #(25 * 20000);
        errors++;
        wrap_up();
    end
endmodule
bind scsi_protocol_microsequencer seq_assertions chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .up_sel_i(up_sel_i), .up_we_i(up_we_i), .up_addr_i(up_addr_i), .up_wdata_i(up_wdata_i),
    .up_rdata_o(up_rdata_o), .up_hw_irq_o(up_hw_irq_o), .hw_intercept_i(hw_intercept_i),
    .hw_irq0_i(hw_irq0_i), .hw_irq1_i(hw_irq1_i), .cbus_rd_o(cbus_rd_o), .cbus_wr_o(cbus_wr_o),
    .running_o(running_o), .stack_fault_o(stack_fault_o));
